// ==== core/tw_timer16.sv ====
// timer16 waveform output mode logic with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module tw_timer16
(
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	// wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output var  logic [31:0] wb_dat_out,
	output var  logic        wb_ack_out,
	// timer tick and pin side
	input  wire logic        tick_in,
	input  wire logic [1:0]  port_data_in,
	output var  logic [1:0]  pin_out,
	output var  logic [1:0]  pin_oe_out,
	output var  logic        irq_out
);
	// ============================================================
	// registers
	logic [7:0]  ctrl_a;
	logic [7:0]  ctrl_b;
	logic [15:0] cmp_buf_a;
	logic [15:0] cmp_buf_b;
	logic [15:0] compare_value_a;
	logic [15:0] compare_value_b;
	logic [15:0] capture_value;
	logic [15:0] count;
	logic        count_down;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	logic [1:0]  pin_dir;
	logic        wave_out_a;
	logic        wave_out_b;

	logic [1:0] chan_a_output_action;
	logic [1:0] chan_b_output_action;
	logic [3:0] wave_mode_sel;
	assign chan_a_output_action = ctrl_a[tw_pkg::ACT_A_LSB +: 2];
	assign chan_b_output_action = ctrl_a[tw_pkg::ACT_B_LSB +: 2];
	assign wave_mode_sel = {ctrl_b[tw_pkg::MODE_HI_LSB +: 2],
		ctrl_a[tw_pkg::MODE_LO_LSB +: 2]};

	// ============================================================
	// mode decode
	tw_pkg::tw_family_t family;
	tw_pkg::tw_update_t upd_at;
	logic [15:0] top;
	always_comb
	begin
		family = tw_pkg::TW_NORMAL;
		unique case (wave_mode_sel)
			4'h0:
				family = tw_pkg::TW_NORMAL;
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb:
				family = tw_pkg::TW_PHASE;
			4'h4, 4'hc:
				family = tw_pkg::TW_CLEAR_ON_MATCH;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf:
				family = tw_pkg::TW_FAST;
			4'h8, 4'h9:
				family = tw_pkg::TW_PHASE_FREQ;
			4'hd:
				family = tw_pkg::TW_RESERVED;
		endcase
		unique case (wave_mode_sel)
			4'h1, 4'h5:
				top = tw_pkg::TOP_8BIT;
			4'h2, 4'h6:
				top = tw_pkg::TOP_9BIT;
			4'h3, 4'h7:
				top = tw_pkg::TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf:
				top = compare_value_a;
			4'h8, 4'ha, 4'hc, 4'he:
				top = capture_value;
			default:
				top = tw_pkg::TOP_MAX;
		endcase
	end
	assign upd_at = family == tw_pkg::TW_PHASE ? tw_pkg::TW_UPD_TOP
		: (family == tw_pkg::TW_FAST || family == tw_pkg::TW_PHASE_FREQ) ? tw_pkg::TW_UPD_BOTTOM
		: tw_pkg::TW_UPD_NOW;

	logic dual;
	logic at_top;
	logic at_bottom;
	logic match_a;
	logic match_b;
	logic toggle_a_ok;
	assign dual      = family == tw_pkg::TW_PHASE || family == tw_pkg::TW_PHASE_FREQ;
	assign at_top    = count == top;
	assign at_bottom = count == tw_pkg::BOTTOM;
	assign match_a   = tick_in && count == compare_value_a;
	assign match_b   = tick_in && count == compare_value_b;
	assign toggle_a_ok = (family == tw_pkg::TW_FAST && wave_mode_sel[3])
		|| (dual && wave_mode_sel[3] && wave_mode_sel[0]);

	// ============================================================
	// counter; reserved mode holds the count
	logic next_down;
	assign next_down = dual && (at_top || (count_down && !at_bottom));
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			count      <= tw_pkg::WORD_RST;
			count_down <= 1'b0;
		end
		else if (tick_in && family != tw_pkg::TW_RESERVED)
		begin
			count_down <= next_down;
			if (next_down)
				count <= count - 16'h0001;
			else if (at_top)
				count <= tw_pkg::BOTTOM;
			else
				count <= count + 16'h0001;
		end
	end

	// ============================================================
	// compare buffer transfer
	logic upd_now;
	assign upd_now = upd_at == tw_pkg::TW_UPD_NOW
		|| (tick_in && upd_at == tw_pkg::TW_UPD_TOP && at_top)
		|| (tick_in && upd_at == tw_pkg::TW_UPD_BOTTOM && at_bottom);
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			compare_value_a <= tw_pkg::WORD_RST;
			compare_value_b <= tw_pkg::WORD_RST;
		end
		else if (upd_now)
		begin
			compare_value_a <= cmp_buf_a;
			compare_value_b <= cmp_buf_b;
		end
	end

	// ============================================================
	// waveform action per channel
	function automatic logic wave_next(input logic cur, input logic [1:0] act,
		input logic match, input logic is_a, input logic cmp_is_top,
		input tw_pkg::tw_family_t fam, input logic dual_m, input logic bot,
		input logic down, input logic tog_ok, input logic tk);
		logic nxt;
		nxt = cur;
		if ((fam == tw_pkg::TW_NORMAL || fam == tw_pkg::TW_CLEAR_ON_MATCH) && match)
			unique case (act)
				tw_pkg::ACT_TOGGLE:
					nxt = !cur;
				tw_pkg::ACT_CLEAR:
					nxt = 1'b0;
				tw_pkg::ACT_SET:
					nxt = 1'b1;
				tw_pkg::ACT_OFF:
					nxt = cur;
			endcase
		else if (fam == tw_pkg::TW_FAST)
		begin
			if (act == tw_pkg::ACT_TOGGLE && is_a && tog_ok && match)
				nxt = !cur;
			else if (act[1] && tk && bot)
				nxt = !act[0];
			else if (act[1] && match && !cmp_is_top)
				nxt = act[0];
		end
		else if (dual_m)
		begin
			if (act == tw_pkg::ACT_TOGGLE && is_a && tog_ok && match)
				nxt = !cur;
			else if (act[1] && match)
				nxt = act[0] ^ down;
		end
		return nxt;
	endfunction

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end
		else
		begin
			wave_out_a <= wave_next(wave_out_a, chan_a_output_action, match_a, 1'b1,
				compare_value_a == top, family, dual, at_bottom, count_down,
				toggle_a_ok, tick_in);
			wave_out_b <= wave_next(wave_out_b, chan_b_output_action, match_b, 1'b0,
				compare_value_b == top, family, dual, at_bottom, count_down,
				toggle_a_ok, tick_in);
		end
	end

	// ============================================================
	// pin override: compare output replaces port data
	// toggle code keeps the port in pwm modes, except channel a in 9/11/14/15
	logic [1:0] pin_route;
	logic [1:0] tog_route;
	logic       pwm;
	assign pwm       = dual || family == tw_pkg::TW_FAST;
	assign tog_route = {!pwm, !pwm || toggle_a_ok};
	assign pin_route = {chan_b_output_action[1] || (chan_b_output_action[0] && tog_route[1]),
		chan_a_output_action[1] || (chan_a_output_action[0] && tog_route[0])};
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pin_out    <= 2'h0;
			pin_oe_out <= 2'h0;
		end
		else
		begin
			pin_out[0] <= pin_route[0] ? wave_out_a : port_data_in[0];
			pin_out[1] <= pin_route[1] ? wave_out_b : port_data_in[1];
			pin_oe_out <= pin_dir;
		end
	end

	// ============================================================
	// events and interrupt
	logic ovf_evt;
	logic [2:0] evt;
	always_comb
	begin
		unique case (family)
			tw_pkg::TW_NORMAL, tw_pkg::TW_CLEAR_ON_MATCH:
				ovf_evt = tick_in && count == tw_pkg::TOP_MAX;
			tw_pkg::TW_PHASE, tw_pkg::TW_PHASE_FREQ:
				ovf_evt = tick_in && at_bottom && count_down;
			tw_pkg::TW_FAST:
				ovf_evt = tick_in && at_top;
			default:
				ovf_evt = 1'b0;
		endcase
	end
	assign evt = {match_b, match_a, ovf_evt};

	logic wr;
	logic rd_ok;
	assign wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
	assign rd_ok = wb_cyc_in && wb_stb_in && !wb_ack_out;

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			irq_stat <= tw_pkg::IRQ_RST;
		else if (wr && wb_adr_in == tw_pkg::OFS_IRQ_STAT && wb_sel_in[0])
			irq_stat <= (irq_stat & ~wb_dat_in[2:0]) | evt;
		else
			irq_stat <= irq_stat | evt;
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_stat & irq_mask);
	end

	// ============================================================
	// register writes
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ctrl_a        <= tw_pkg::CTRL_RST;
			ctrl_b        <= tw_pkg::CTRL_RST;
			cmp_buf_a     <= tw_pkg::WORD_RST;
			cmp_buf_b     <= tw_pkg::WORD_RST;
			capture_value <= tw_pkg::WORD_RST;
			irq_mask      <= tw_pkg::IRQ_RST;
			pin_dir       <= 2'h0;
		end
		else if (wr && wb_sel_in[0])
		begin
			unique case (wb_adr_in)
				tw_pkg::OFS_CTRL_A:
					ctrl_a <= wb_dat_in[7:0] & 8'hf3;
				tw_pkg::OFS_CTRL_B:
					ctrl_b <= wb_dat_in[7:0] & 8'hdf;
				tw_pkg::OFS_CMP_A:
					cmp_buf_a <= wb_dat_in[15:0];
				tw_pkg::OFS_CMP_B:
					cmp_buf_b <= wb_dat_in[15:0];
				tw_pkg::OFS_CAPTURE:
					capture_value <= wb_dat_in[15:0];
				tw_pkg::OFS_IRQ_MASK:
					irq_mask <= wb_dat_in[2:0];
				tw_pkg::OFS_PIN_DIR:
					pin_dir <= wb_dat_in[1:0];
				default:
					ctrl_a <= ctrl_a;
			endcase
		end
	end

	// ============================================================
	// read data and ack, one wait state
	logic [31:0] rd_mux;
	always_comb
	begin
		unique case (wb_adr_in)
			tw_pkg::OFS_CTRL_A:   rd_mux = {24'h000000, ctrl_a};
			tw_pkg::OFS_CTRL_B:   rd_mux = {24'h000000, ctrl_b};
			tw_pkg::OFS_CMP_A:    rd_mux = {16'h0000, cmp_buf_a};
			tw_pkg::OFS_CMP_B:    rd_mux = {16'h0000, cmp_buf_b};
			tw_pkg::OFS_CAPTURE:  rd_mux = {16'h0000, capture_value};
			tw_pkg::OFS_COUNT:    rd_mux = {16'h0000, count};
			tw_pkg::OFS_IRQ_STAT: rd_mux = {29'h00000000, irq_stat};
			tw_pkg::OFS_IRQ_MASK: rd_mux = {29'h00000000, irq_mask};
			tw_pkg::OFS_PIN_DIR:  rd_mux = {30'h00000000, pin_dir};
			default:              rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end
		else
		begin
			wb_ack_out <= rd_ok;
			wb_dat_out <= rd_ok ? rd_mux : 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// ==== include/tw_pkg.sv ====
// package: register map, mode codes and field layout for the timer waveform block
package tw_pkg;
	// ============================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL_A   = 8'h00;
	localparam logic [7:0] OFS_CTRL_B   = 8'h04;
	localparam logic [7:0] OFS_CMP_A    = 8'h08;
	localparam logic [7:0] OFS_CMP_B    = 8'h0c;
	localparam logic [7:0] OFS_CAPTURE  = 8'h10;
	localparam logic [7:0] OFS_COUNT    = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFS_PIN_DIR  = 8'h20;
	// ============================================================
	// field positions
	localparam int ACT_A_LSB   = 6;
	localparam int ACT_B_LSB   = 4;
	localparam int MODE_LO_LSB = 0;
	localparam int MODE_HI_LSB = 3;
	localparam int IRQ_OVF     = 0;
	localparam int IRQ_CMPA    = 1;
	localparam int IRQ_CMPB    = 2;
	// ============================================================
	// reset values
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [2:0]  IRQ_RST  = 3'h0;
	// ============================================================
	// counter limits
	localparam logic [15:0] TOP_MAX   = 16'hffff;
	localparam logic [15:0] TOP_8BIT  = 16'h00ff;
	localparam logic [15:0] TOP_9BIT  = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] BOTTOM    = 16'h0000;
	// ============================================================
	// action codes
	localparam logic [1:0] ACT_OFF    = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;
	// ============================================================
	// mode families
	typedef enum logic [2:0] {
		TW_NORMAL,
		TW_CLEAR_ON_MATCH,
		TW_PHASE,
		TW_PHASE_FREQ,
		TW_FAST,
		TW_RESERVED
	} tw_family_t;
	typedef enum logic [1:0] {
		TW_UPD_NOW,
		TW_UPD_TOP,
		TW_UPD_BOTTOM
	} tw_update_t;
endpackage

// ==== verif/tw_gpio_pad.sv ====
// partner: port pads with pull-up
`timescale 1ns/1ps
`default_nettype none
module tw_gpio_pad
(
	// block side
	input  wire logic [1:0] pin_in,
	input  wire logic [1:0] oe_in,
	// pad level
	output wire logic [1:0] pad_out
);
	// disabled driver leaves the pad to the pull-up
	assign pad_out = (pin_in & oe_in) | ~oe_in;
endmodule
`default_nettype wire

// ==== verif/tw_timer16_sva.sv ====
// checker: bus, pin and interrupt assertions for the timer block
`timescale 1ns/1ps
`default_nettype none
module tw_timer16_sva
(
	// clock and reset
	input wire logic        sys_clk_in,
	input wire logic        rst_b_in,
	// wishbone
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [7:0]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	// pins
	input wire logic [1:0]  port_data_in,
	input wire logic [1:0]  pin_out,
	input wire logic [1:0]  pin_oe_out,
	input wire logic        irq_out
);
	// ============================================================
	// register shadows
	logic [7:0] ctrl_a;
	logic [1:0] dir;
	logic [2:0] mask;
	logic       wr;
	logic       ca_busy;
	assign wr = wb_ack_out && wb_we_in && wb_sel_in[0];
	assign ca_busy = wb_cyc_in && wb_stb_in && wb_we_in && wb_adr_in == tw_pkg::OFS_CTRL_A;
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ctrl_a <= 8'h00;
			dir    <= 2'h0;
			mask   <= 3'h0;
		end
		else if (wr)
		begin
			if (wb_adr_in == tw_pkg::OFS_CTRL_A)
				ctrl_a <= wb_dat_in[7:0];
			if (wb_adr_in == tw_pkg::OFS_PIN_DIR)
				dir <= wb_dat_in[1:0];
			if (wb_adr_in == tw_pkg::OFS_IRQ_MASK)
				mask <= wb_dat_in[2:0];
		end
	end
	// ============================================================
	// assertions
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	a_ack_one_wait: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack late");
	a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
		else $error("read data without ack");
	a_pin_a_port: assert property (ctrl_a[7:6] == 2'h0 && $past(ctrl_a[7:6]) == 2'h0 && !ca_busy
		|=> pin_out[0] == $past(port_data_in[0])) else $error("pin a not port");
	a_pin_b_port: assert property (ctrl_a[5:4] == 2'h0 && $past(ctrl_a[5:4]) == 2'h0 && !ca_busy
		|=> pin_out[1] == $past(port_data_in[1])) else $error("pin b not port");
	a_oe_from_dir: assert property (pin_oe_out == dir)
		else $error("driver enable differs");
	a_irq_mask_off: assert property (wr && wb_adr_in == tw_pkg::OFS_IRQ_MASK
		&& wb_dat_in[2:0] == 3'h0 |=> !irq_out) else $error("irq with zero mask");
	a_irq_needs_mask: assert property ($rose(irq_out) |-> mask != 3'h0)
		else $error("irq rose unmasked");
	a_reset_quiet: assert property ($rose(rst_b_in) |-> pin_out == 2'h0
		&& pin_oe_out == 2'h0 && !irq_out) else $error("outputs not idle");
	cover property (wr);
	cover property ($rose(irq_out));
	cover property ($fell(pin_out[0]));
endmodule
bind tw_timer16 tw_timer16_sva tw_timer16_sva_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
	.wb_ack_out(wb_ack_out), .port_data_in(port_data_in), .pin_out(pin_out),
	.pin_oe_out(pin_oe_out), .irq_out(irq_out));
`default_nettype wire

// ==== verif/tw_timer16_tb.sv ====
// bench: register, pin and waveform scenarios for the timer block
`timescale 1ns/1ps
`default_nettype none
module tw_timer16_tb;
	logic        clk;
	logic        rst_b;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        tick;
	logic [7:0]  adr;
	logic [31:0] dat;
	logic [31:0] rd;
	logic [31:0] q;
	logic [1:0]  pdat;
	logic [1:0]  pin;
	logic [1:0]  oe;
	wire  [1:0]  pad;
	logic        ack;
	logic        irq;
	int          n_fail;
	int          checks;
	tw_timer16 tw_timer16_i (.sys_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1),
		.wb_dat_in(dat), .wb_dat_out(rd), .wb_ack_out(ack), .tick_in(tick),
		.port_data_in(pdat), .pin_out(pin), .pin_oe_out(oe), .irq_out(irq));
	tw_gpio_pad tw_gpio_pad_i (.pin_in(pin), .oe_in(oe), .pad_out(pad));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ============================================================
	// shared tasks
	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (ack !== 1'b1 && k < 20);
		chk(k < 20, 1'b1);
		if (k >= 20)
			end_sim();
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic tk(input int n);
		@(posedge clk);
		tick <= 1'b1;
		repeat (n) @(posedge clk);
		tick <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic wt(input logic v, output int k);
		k = 0;
		while (pin[0] !== v && k < 1200)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 1200)
		begin
			n_fail++;
			end_sim();
		end
	endtask
	// ============================================================
	// scenarios
	task automatic s_reset();
		rd_chk(tw_pkg::OFS_CTRL_A, 32'h0);
		rd_chk(tw_pkg::OFS_CTRL_B, 32'h0);
		chk({30'h0, pin}, 32'h1);
		chk({30'h0, pad}, 32'h3);
		rd_chk(8'h40, 32'h0);
	endtask
	task automatic s_normal();
		wb(1'b1, tw_pkg::OFS_PIN_DIR, 32'h3);
		chk({30'h0, oe}, 32'h3);
		wb(1'b1, tw_pkg::OFS_CMP_A, 32'h2);
		wb(1'b1, tw_pkg::OFS_CTRL_A, 32'hc0);
		chk({30'h0, pad}, 32'h0);
		tk(3);
		chk({30'h0, pin}, 32'h1);
		rd_chk(tw_pkg::OFS_COUNT, 32'h3);
		rd_chk(tw_pkg::OFS_IRQ_STAT, 32'h6);
		wb(1'b1, tw_pkg::OFS_IRQ_MASK, 32'h2);
		chk(irq, 1'b1);
		wb(1'b1, tw_pkg::OFS_IRQ_STAT, 32'h2);
		chk(irq, 1'b0);
		rd_chk(tw_pkg::OFS_IRQ_STAT, 32'h4);
		wb(1'b1, tw_pkg::OFS_IRQ_MASK, 32'h0);
		wb(1'b1, tw_pkg::OFS_CMP_B, 32'h4);
		wb(1'b1, tw_pkg::OFS_CTRL_A, 32'h10);
		tk(2);
		chk({30'h0, pin}, 32'h3);
		wb(1'b1, tw_pkg::OFS_CTRL_A, 32'h20);
		wb(1'b1, tw_pkg::OFS_CMP_B, 32'h6);
		tk(2);
		chk({30'h0, pin}, 32'h1);
		wb(1'b1, tw_pkg::OFS_CMP_A, 32'h10);
	endtask
	task automatic s_pwm(input logic [7:0] cb, input logic [7:0] ca, input logic lv, input int w);
		int k;
		wb(1'b1, tw_pkg::OFS_IRQ_STAT, 32'h7);
		wb(1'b1, tw_pkg::OFS_CTRL_B, {24'h0, cb});
		wb(1'b1, tw_pkg::OFS_CTRL_A, {24'h0, ca});
		tick <= 1'b1;
		wt(!lv, k);
		wt(lv, k);
		wt(!lv, k);
		chk(k, w);
		tick <= 1'b0;
		rd_chk(tw_pkg::OFS_IRQ_STAT, 32'h7);
	endtask
	task automatic s_pwm_port();
		pdat <= 2'h2;
		wb(1'b1, tw_pkg::OFS_CTRL_A, 32'h51);
		chk({30'h0, pin}, 32'h2);
		wb(1'b1, tw_pkg::OFS_CTRL_B, 32'h08);
		chk({30'h0, pin}, 32'h2);
	endtask
	initial
	begin
		n_fail = 0;
		checks = 0;
		rst_b = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		tick = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		pdat = 2'h1;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		s_reset();
		s_normal();
		s_pwm(8'h08, 8'h81, 1'b1, 16);
		s_pwm(8'h08, 8'hc1, 1'b0, 16);
		s_pwm(8'h00, 8'h81, 1'b1, 32);
		s_pwm(8'h00, 8'hc1, 1'b0, 32);
		s_pwm_port();
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(tw_pkg::OFS_CTRL_A, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
